// ### core/preset_consts.svh
// constants for the analog preset and receive mask command block
`ifndef PRESET_CONSTS_SVH
`define PRESET_CONSTS_SVH
// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ADDR_OP_CTRL   6'h02
`define ADDR_ISO_A     6'h05
`define ADDR_AUX_DEF   6'h09
`define ADDR_RX_CFG1   6'h0a
`define ADDR_RX_CFG3   6'h0c
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_OP_CTRL    8'h00
`define RST_ISO_A      8'h00
`define RST_AUX_DEF    8'h00
`define RST_RX_CFG1    8'h00
`define RST_RX_CFG3    8'h00
`define RD_UNMAPPED    8'h00
// ----------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------
`define OP_RX_EN       6
`define OP_RX_CHN      5
`define OP_TX_EN       3
`define ISO_START_LEN  5
`define AUX_TX_AM      5
`define AUX_FD_ON      4
`define RX1_CH_PICK    7
`define RX1_AMD_MIX    6
`define RX1_LP_HI      5
`define RX1_LP_LO      3
`define RX1_Z_HI       2
`define RX1_Z_LO       0
`define RX3_CLIP       1
`define RX3_GAIN_CUT   0
// ----------------------------------------------------------------
// mode codes and rate codes
// ----------------------------------------------------------------
`define MODE_ISO_A     4'h1
`define MODE_ISO_B     4'h2
`define MODE_ISO_F     4'h3
`define MODE_VICINITY  4'h4
`define MODE_TYPE1     4'h5
`define MODE_NFC_INIT  4'h6
`define MODE_NFC_TGT   4'h7
`define MODE_TGT_A     4'h8
`define MODE_TGT_B     4'h9
`define MODE_TGT_F     4'ha
`define RATE_106       3'h0
`define RATE_212       3'h1
`define RATE_424       3'h2
`define RATE_848       3'h3
// ----------------------------------------------------------------
// filter settings
// ----------------------------------------------------------------
`define LP_R106        3'h0
`define LP_R212        3'h1
`define LP_R424        3'h2
`define LP_R848        3'h3
`define LP_HIGH        3'h4
`define ZERO_NFC       3'h1
`define ZERO_ISO_B     3'h4
`define ZERO_OTHER     3'h2
`endif

// ### core/preset_pkg.sv
// types and shared lookups for the analog preset block
`default_nettype none
`include "preset_consts.svh"
package preset_pkg;
  typedef logic [7:0] byte_t;      // one register
  typedef logic [3:0] mode_code_t; // protocol mode
  typedef logic [2:0] rate_code_t; // bit rate index

  // nfc active communication, initiator or target
  function automatic logic is_nfc(input mode_code_t m);
    return (m == `MODE_NFC_INIT) || (m == `MODE_NFC_TGT);
  endfunction

  // low-pass choice follows the receive rate
  function automatic logic [2:0] lp_for(input rate_code_t r);
    unique case (r)
      `RATE_106: return `LP_R106;
      `RATE_212: return `LP_R212;
      `RATE_424: return `LP_R424;
      `RATE_848: return `LP_R848;
      default:   return `LP_HIGH;
    endcase
  endfunction

  // zero setting follows the mode family
  function automatic logic [2:0] zero_for(input mode_code_t m);
    if (is_nfc(m))
      return `ZERO_NFC;
    if ((m == `MODE_ISO_B) || (m == `MODE_TGT_B))
      return `ZERO_ISO_B;
    return `ZERO_OTHER;
  endfunction
endpackage
`default_nettype wire

// ### core/analog_preset_lookup.sv
// preset value for each register, write mask for op, iso and aux only, from mode and rates
`default_nettype none
`include "preset_consts.svh"
module analog_preset_lookup
(
  // mode context
  input  wire preset_pkg::mode_code_t mode,
  input  wire preset_pkg::rate_code_t tx_rate,
  input  wire preset_pkg::rate_code_t rx_rate,
  // values and masks
  output preset_pkg::byte_t           op_val,
  output preset_pkg::byte_t           op_msk,
  output preset_pkg::byte_t           iso_val,
  output preset_pkg::byte_t           iso_msk,
  output preset_pkg::byte_t           aux_val,
  output preset_pkg::byte_t           aux_msk,
  output preset_pkg::byte_t           rx1_val,
  output preset_pkg::byte_t           rx3_val
);
  logic nfc;     // nfc active communication
  logic tx_off;  // target modes and nfc initiator
  logic ook;     // modes that send ook
  logic am;      // modes that send am

  // ----------------------------------------------------------------
  // mode classes
  // ----------------------------------------------------------------
  always_comb
  begin
    nfc    = preset_pkg::is_nfc(mode);
    tx_off = (mode == `MODE_NFC_INIT) || (mode == `MODE_NFC_TGT) ||
             (mode == `MODE_TGT_A) || (mode == `MODE_TGT_B) ||
             (mode == `MODE_TGT_F);
    ook    = (mode == `MODE_ISO_A) || (mode == `MODE_TGT_A) ||
             (mode == `MODE_TYPE1) || (nfc && (tx_rate == `RATE_106));
    am     = (mode == `MODE_ISO_B) || (mode == `MODE_TGT_B) ||
             (mode == `MODE_ISO_F) || (mode == `MODE_TGT_F) ||
             (nfc && (tx_rate != `RATE_106));
  end

  // ----------------------------------------------------------------
  // per-register values; bits outside a mask stay untouched
  // ----------------------------------------------------------------
  always_comb
  begin
    op_val  = 8'h00;
    op_msk  = 8'h00;
    iso_val = 8'h00;
    iso_msk = 8'h00;
    aux_val = 8'h00;
    aux_msk = 8'h00;
    rx1_val = 8'h00;
    rx3_val = 8'h00;
    op_val[`OP_RX_CHN]         = 1'b1;
    op_msk[`OP_RX_CHN]         = nfc;
    op_msk[`OP_TX_EN]          = tx_off;
    iso_val[`ISO_START_LEN]    = 1'b1;
    iso_msk[`ISO_START_LEN]    = nfc;
    aux_val[`AUX_TX_AM]        = am;
    aux_msk[`AUX_TX_AM]        = ook | am;
    aux_val[`AUX_FD_ON]        = nfc;
    aux_msk[`AUX_FD_ON]        = 1'b1;
    rx1_val[`RX1_CH_PICK]      = 1'b0;
    // peak detector up to fc/16, mixer above
    rx1_val[`RX1_AMD_MIX]      = rx_rate > `RATE_848;
    rx1_val[`RX1_LP_HI:`RX1_LP_LO] =
      preset_pkg::lp_for(rx_rate);
    rx1_val[`RX1_Z_HI:`RX1_Z_LO] =
      preset_pkg::zero_for(mode);
    rx3_val[`RX3_CLIP]         = nfc;
    rx3_val[`RX3_GAIN_CUT]     = nfc;
  end
endmodule // analog_preset_lookup
`default_nettype wire

// ### core/analog_preset_rx_mask.sv
// analog preset and receive mask/unmask command execution
`default_nettype none
`include "preset_consts.svh"
module analog_preset_rx_mask
(
  // clock, reset, enable
  input  wire logic                   CORE_CLK,
  input  wire logic                   SRST,
  input  wire logic                   CE,
  // register access
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  input  wire logic [5:0]             REG_ADDR,
  input  wire preset_pkg::byte_t      REG_WDATA,
  output preset_pkg::byte_t           REG_RDATA,
  output logic                        REG_RVALID,
  // mode context
  input  wire preset_pkg::mode_code_t MODE_DEF,
  input  wire preset_pkg::rate_code_t TX_RATE,
  input  wire preset_pkg::rate_code_t RX_RATE,
  // direct command strobes
  input  wire logic                   PRESET_CMD,
  input  wire logic                   MASK_CMD,
  input  wire logic                   UNMASK_CMD,
  // mask receive timer
  input  wire logic                   MASK_TIMER_MASK,
  output logic                        MASK_TIMER_RST,
  // receiver control
  output logic                        RX_ON,
  output logic                        RX_FRAMING_EN,
  output logic                        CMD_TERM_IRQ,
  // register contents
  output preset_pkg::byte_t           OP_CTRL,
  output preset_pkg::byte_t           ISO_A_SET,
  output preset_pkg::byte_t           AUX_DEF,
  output preset_pkg::byte_t           RX_CFG1,
  output preset_pkg::byte_t           RX_CFG3
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  preset_pkg::byte_t op_q, iso_q, aux_q, rx1_q, rx3_q; // registers
  preset_pkg::byte_t op_val, op_msk;    // preset operation control
  preset_pkg::byte_t iso_val, iso_msk;  // preset 106k settings
  preset_pkg::byte_t aux_val, aux_msk;  // preset auxiliary
  preset_pkg::byte_t rx1_val, rx3_val;  // preset receiver config
  preset_pkg::byte_t rdata_q;           // read data
  logic              rvalid_q;          // read data valid
  logic              rx_en;             // receiver enable bit
  logic              mask_go, unmask_go; // accepted commands
  logic              mask_cmd_q, mask_cmd_d; // command mask state
  logic              tmr_ovr_q, tmr_ovr_d;   // timer overridden
  logic              eff_mask;          // combined mask
  logic              rx_on_q;           // receive active
  logic              frm_en_q;          // framing enable
  logic              tmr_rst_q;         // timer reset pulse
  logic              irq_q;             // termination pulse
  logic              preset_go;         // preset this cycle

  // ----------------------------------------------------------------
  // preset table
  // ----------------------------------------------------------------
  analog_preset_lookup u_lookup
  (
    .mode    (MODE_DEF),
    .tx_rate (TX_RATE),
    .rx_rate (RX_RATE),
    .op_val  (op_val),
    .op_msk  (op_msk),
    .iso_val (iso_val),
    .iso_msk (iso_msk),
    .aux_val (aux_val),
    .aux_msk (aux_msk),
    .rx1_val (rx1_val),
    .rx3_val (rx3_val)
  );

  // host write first, preset bits on top; the rest is kept
  function automatic preset_pkg::byte_t merge
  (
    input preset_pkg::byte_t cur,
    input logic              wr,
    input preset_pkg::byte_t wd,
    input logic              pr,
    input preset_pkg::byte_t val,
    input preset_pkg::byte_t msk
  );
    preset_pkg::byte_t t;
    t = wr ? wd : cur;
    return pr ? ((t & ~msk) | (val & msk)) : t;
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    return REG_WR && (a == b);
  endfunction

  assign preset_go = CE && PRESET_CMD;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // operation control: host writes, preset touches channel and tx
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      op_q <= `RST_OP_CTRL;
    else if (CE)
      op_q <= merge(op_q, hit(REG_ADDR, `ADDR_OP_CTRL), REG_WDATA,
                    PRESET_CMD, op_val, op_msk);
  end

  // 106k settings: start and length byte insertion
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      iso_q <= `RST_ISO_A;
    else if (CE)
      iso_q <= merge(iso_q, hit(REG_ADDR, `ADDR_ISO_A), REG_WDATA,
                     PRESET_CMD, iso_val, iso_msk);
  end

  // auxiliary definition: modulation kind and field detector
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      aux_q <= `RST_AUX_DEF;
    else if (CE)
      aux_q <= merge(aux_q, hit(REG_ADDR, `ADDR_AUX_DEF), REG_WDATA,
                     PRESET_CMD, aux_val, aux_msk);
  end

  // receiver config 1: channel pick only in nfc, rest always
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      rx1_q <= `RST_RX_CFG1;
    else if (CE)
      rx1_q <= merge(rx1_q, hit(REG_ADDR, `ADDR_RX_CFG1), REG_WDATA,
                     PRESET_CMD, rx1_val,
                     {preset_pkg::is_nfc(MODE_DEF), 7'h7f});
  end

  // receiver config 3: clip and gain cut, low two bits
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      rx3_q <= `RST_RX_CFG3;
    else if (CE)
      rx3_q <= merge(rx3_q, hit(REG_ADDR, `ADDR_RX_CFG3), REG_WDATA,
                     PRESET_CMD, rx3_val, 8'h03);
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // unmapped addresses read as zero; data one cycle after the strobe
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      rdata_q  <= `RD_UNMAPPED;
      rvalid_q <= 1'b0;
    end
    else if (CE)
    begin
      rvalid_q <= REG_RD;
      if (REG_RD)
      begin
        unique case (REG_ADDR)
          `ADDR_OP_CTRL: rdata_q <= op_q;
          `ADDR_ISO_A:   rdata_q <= iso_q;
          `ADDR_AUX_DEF: rdata_q <= aux_q;
          `ADDR_RX_CFG1: rdata_q <= rx1_q;
          `ADDR_RX_CFG3: rdata_q <= rx3_q;
          default:       rdata_q <= `RD_UNMAPPED;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // receive mask control
  // ----------------------------------------------------------------
  // commands need the receiver on; both same cycle, mask wins.
  // any cycle may carry a command, so chained ones all land.
  always_comb
  begin
    rx_en     = op_q[`OP_RX_EN];
    mask_go   = CE && rx_en && MASK_CMD;
    unmask_go = CE && rx_en && UNMASK_CMD && !MASK_CMD;
    mask_cmd_d = mask_cmd_q;
    if (mask_go)
      mask_cmd_d = 1'b1;
    else if (unmask_go)
      mask_cmd_d = 1'b0;
    // the timer's mask lags its reset, so hide it until it drops
    tmr_ovr_d = tmr_ovr_q;
    if (mask_go || !MASK_TIMER_MASK)
      tmr_ovr_d = 1'b0;
    if (unmask_go && MASK_TIMER_MASK)
      tmr_ovr_d = 1'b1;
    eff_mask = mask_cmd_d ||
               (MASK_TIMER_MASK && !tmr_ovr_d);
  end

  // mask state flops
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      mask_cmd_q <= 1'b0;
      tmr_ovr_q  <= 1'b0;
    end
    else if (CE)
    begin
      mask_cmd_q <= mask_cmd_d;
      tmr_ovr_q  <= tmr_ovr_d;
    end
  end

  // receiver outputs, registered so they leave glitch free
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      rx_on_q   <= 1'b0;
      frm_en_q  <= 1'b1;
      tmr_rst_q <= 1'b0;
    end
    else if (CE)
    begin
      rx_on_q   <= rx_en && !eff_mask;
      frm_en_q  <= !eff_mask;
      tmr_rst_q <= unmask_go && MASK_TIMER_MASK;
    end
  end

  // termination pulse only for the preset, never for mask commands
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      irq_q <= 1'b0;
    else if (CE)
      irq_q <= PRESET_CMD;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign REG_RDATA      = rdata_q;
  assign REG_RVALID     = rvalid_q;
  assign MASK_TIMER_RST = tmr_rst_q;
  assign RX_ON          = rx_on_q;
  assign RX_FRAMING_EN  = frm_en_q;
  assign CMD_TERM_IRQ   = irq_q;
  assign OP_CTRL        = op_q;
  assign ISO_A_SET      = iso_q;
  assign AUX_DEF        = aux_q;
  assign RX_CFG1        = rx1_q;
  assign RX_CFG3        = rx3_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  sequence s_preset_nfc;
    preset_go && preset_pkg::is_nfc(MODE_DEF);
  endsequence

  sequence s_unmask_timer;
    unmask_go && MASK_TIMER_MASK && !REG_WR;
  endsequence

  // a chained unmask right after the mask may legally reopen framing
  sequence s_mask_then_idle;
    mask_go ##1 !unmask_go;
  endsequence

  a_preset_chn: assert property
    (s_preset_nfc |=> OP_CTRL[`OP_RX_CHN] && ISO_A_SET[`ISO_START_LEN]
     && !RX_CFG1[`RX1_CH_PICK])
    else $error("nfc preset missed channel bits");
  a_preset_txoff: assert property
    (preset_go && ((MODE_DEF == `MODE_TGT_A) ||
     (MODE_DEF == `MODE_NFC_INIT)) |=> !OP_CTRL[`OP_TX_EN])
    else $error("preset left transmitter on");
  a_preset_mod: assert property
    (preset_go && (MODE_DEF == `MODE_ISO_B)
     |=> AUX_DEF[`AUX_TX_AM] && !AUX_DEF[`AUX_FD_ON])
    else $error("preset modulation wrong for iso b");
  a_preset_fd: assert property
    (preset_go |=> AUX_DEF[`AUX_FD_ON] ==
     preset_pkg::is_nfc($past(MODE_DEF)))
    else $error("field detector preset wrong");
  a_preset_rx1: assert property
    (preset_go && (RX_RATE <= `RATE_848)
     |=> !RX_CFG1[`RX1_AMD_MIX] && RX_CFG1[`RX1_LP_HI:`RX1_LP_LO]
     == preset_pkg::lp_for($past(RX_RATE)))
    else $error("demodulator or low-pass preset wrong");
  a_preset_zero: assert property
    (preset_go |=> RX_CFG1[`RX1_Z_HI:`RX1_Z_LO] ==
     preset_pkg::zero_for($past(MODE_DEF)))
    else $error("stage zero preset wrong");
  a_preset_rx3: assert property
    (preset_go |=> {RX_CFG3[`RX3_CLIP], RX_CFG3[`RX3_GAIN_CUT]} ==
     {2{preset_pkg::is_nfc($past(MODE_DEF))}})
    else $error("clip and gain cut preset wrong");
  a_preset_keep: assert property
    (preset_go && !REG_WR |=>
     OP_CTRL[7:6] == $past(OP_CTRL[7:6]) &&
     RX_CFG3[7:2] == $past(RX_CFG3[7:2]))
    else $error("preset changed a bit outside its set");
  a_mask_drop: assert property
    (mask_go |=> !RX_ON && !RX_FRAMING_EN)
    else $error("mask did not drop receive");
  a_mask_hold: assert property
    (s_mask_then_idle |=> !RX_FRAMING_EN)
    else $error("mask did not hold framing off");
  a_unmask_up: assert property
    (unmask_go && !MASK_TIMER_MASK |=> RX_ON && RX_FRAMING_EN)
    else $error("unmask did not enable receive");
  a_mask_or: assert property
    (CE && MASK_TIMER_MASK && !tmr_ovr_q && !UNMASK_CMD |=> !RX_ON)
    else $error("timer mask did not hold receive off");
  a_unmask_tmr: assert property
    (s_unmask_timer |=> RX_ON && RX_FRAMING_EN && MASK_TIMER_RST)
    else $error("unmask during timer did not enable");
  a_ignore_off: assert property
    (CE && !rx_en |=> mask_cmd_q == $past(mask_cmd_q))
    else $error("mask command taken with receiver off");
  a_no_irq: assert property
    (CE && (MASK_CMD || UNMASK_CMD) && !PRESET_CMD |=> !CMD_TERM_IRQ)
    else $error("mask command raised termination irq");
endmodule // analog_preset_rx_mask
`default_nettype wire

// ### bench/host_cmd_model.sv
// host model: register accesses, direct commands, mask timer
`default_nettype none
`include "preset_consts.svh"
module host_cmd_model
(
  // clock
  input  wire logic                  CORE_CLK,
  // register access
  output var logic                   CE,
  output var logic                   REG_WR,
  output var logic                   REG_RD,
  output var logic [5:0]             REG_ADDR,
  output var preset_pkg::byte_t      REG_WDATA,
  input  wire preset_pkg::byte_t     REG_RDATA,
  input  wire logic                  REG_RVALID,
  // mode context and command strobes
  output var preset_pkg::mode_code_t MODE_DEF,
  output var preset_pkg::rate_code_t TX_RATE,
  output var preset_pkg::rate_code_t RX_RATE,
  output var logic                   PRESET_CMD,
  output var logic                   MASK_CMD,
  output var logic                   UNMASK_CMD,
  // mask receive timer
  output var logic                   MASK_TIMER_MASK,
  input  wire logic                  MASK_TIMER_RST
);
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------
  // idle levels from time zero
  // --------------------------------------------------------------
  initial
  begin
    {CE, REG_WR, REG_RD, PRESET_CMD} = 4'h1 << 3;
    {MASK_CMD, UNMASK_CMD, MASK_TIMER_MASK} = 3'h0;
    {REG_ADDR, REG_WDATA} = 14'h0000;
    {MODE_DEF, TX_RATE, RX_RATE} = 10'h000;
  end

  // timer drops its mask once told to reset
  always @(posedge CORE_CLK)
    if (MASK_TIMER_RST)
      MASK_TIMER_MASK <= 1'b0;

  // --------------------------------------------------------------
  // bus and command tasks, one strobe cycle each, two for chained commands
  // --------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input preset_pkg::byte_t d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask

  // data and valid stand for the cycle after the strobe edge, so both
  // are taken at the next edge, before that edge's updates land
  task automatic rd(input logic [5:0] a, output preset_pkg::byte_t d,
                    output logic v);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    @(posedge CORE_CLK);
    v = REG_RVALID;
    d = REG_RDATA;
  endtask

  // stream modes are never passed here
  task automatic preset(input preset_pkg::mode_code_t m,
                        input preset_pkg::rate_code_t r);
    @(posedge CORE_CLK);
    MODE_DEF <= m;
    TX_RATE <= r;
    RX_RATE <= r;
    PRESET_CMD <= 1'b1;
    @(posedge CORE_CLK);
    PRESET_CMD <= 1'b0;
  endtask

  // two command cycles {mask, unmask}, chained back to back
  task automatic cmds(input logic [1:0] a, input logic [1:0] b);
    @(posedge CORE_CLK);
    {MASK_CMD, UNMASK_CMD} <= a;
    @(posedge CORE_CLK);
    {MASK_CMD, UNMASK_CMD} <= b;
    if (b != 2'b00)
    begin
      @(posedge CORE_CLK);
      {MASK_CMD, UNMASK_CMD} <= 2'b00;
    end
  endtask

  // timer mask level, changed after an edge
  task automatic set_timer(input logic v);
    @(posedge CORE_CLK);
    MASK_TIMER_MASK <= v;
  endtask

  // clock enable level, changed after an edge
  task automatic set_ce(input logic v);
    @(posedge CORE_CLK);
    CE <= v;
  endtask
endmodule // host_cmd_model
`default_nettype wire

// ### bench/analog_preset_rx_mask_tb.sv
// self-checking bench for the analog preset and receive mask block
`default_nettype none
`include "preset_consts.svh"
module analog_preset_rx_mask_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK, SRST, CE, REG_WR, REG_RD, REG_RVALID, PRESET_CMD;
  logic MASK_CMD, UNMASK_CMD, MASK_TIMER_MASK, MASK_TIMER_RST;
  logic RX_ON, RX_FRAMING_EN, CMD_TERM_IRQ, rv;
  logic [5:0]             REG_ADDR;
  preset_pkg::mode_code_t MODE_DEF;
  preset_pkg::rate_code_t TX_RATE, RX_RATE;
  preset_pkg::byte_t      REG_WDATA, REG_RDATA, OP_CTRL, ISO_A_SET;
  preset_pkg::byte_t      AUX_DEF, RX_CFG1, RX_CFG3, rd_q;
  int                     errors, check_count, cyc;

  analog_preset_rx_mask u_analog_preset_rx_mask (.*);
  host_cmd_model        u_host_cmd_model (.*);

  // --------------------------------------------------------------
  // clock, timeout and reporting
  // --------------------------------------------------------------
  initial
  begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // about 125 cycles of work; a hang is cut far above that
  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      stop_test();
    end
  end

  task automatic check(input preset_pkg::byte_t got,
                       input preset_pkg::byte_t exp, input string s);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  // readback of a written register, unmapped read gives zero
  task automatic t_regs;
    u_host_cmd_model.wr(`ADDR_AUX_DEF, 8'h5a);
    u_host_cmd_model.rd(`ADDR_AUX_DEF, rd_q, rv);
    check(rd_q, 8'h5a, "readback");
    check({7'h00, rv}, 8'h01, "rvalid");
    u_host_cmd_model.rd(6'h3f, rd_q, rv);
    check(rd_q, 8'h00, "unmapped");
    $display("t_regs done");
  endtask

  // all bits start at one so untouched bits show up
  task automatic t_preset;
    logic [5:0]  ad[5] = '{`ADDR_OP_CTRL, `ADDR_ISO_A, `ADDR_AUX_DEF,
                           `ADDR_RX_CFG1, `ADDR_RX_CFG3};
    logic [3:0]  md[6] = '{`MODE_NFC_INIT, `MODE_NFC_TGT, `MODE_ISO_B,
                           `MODE_TGT_A, `MODE_ISO_A, `MODE_TGT_F};
    // the last entry runs above fc/16 to reach the mixer path
    logic [2:0]  rt[6] = '{`RATE_106, `RATE_106, `RATE_212,
                           `RATE_106, `RATE_848, 3'h4};
    logic [39:0] ex[6] = '{40'hf7ffdf01ff, 40'hf7ffdf01ff,
                           40'hffffef8cfc, 40'hf7ffcf82fc,
                           40'hffffcf9afc, 40'hf7ffefe2fc};
    for (int i = 0; i < 6; i++)
    begin
      for (int j = 0; j < 5; j++)
        u_host_cmd_model.wr(ad[j], 8'hff);
      u_host_cmd_model.preset(md[i], rt[i]);
      #1;
      check({7'h00, CMD_TERM_IRQ}, 8'h01, "irq");
      check(OP_CTRL, ex[i][39:32], "op");
      check(ISO_A_SET, ex[i][31:24], "iso");
      check(AUX_DEF, ex[i][23:16], "aux");
      check(RX_CFG1, ex[i][15:8], "rx1");
      check(RX_CFG1[2:0], ex[i][10:8], "zero");
      check(RX_CFG3, ex[i][7:0], "rx3");
    end
    $display("t_preset done");
  endtask

  // mask, unmask, chaining, timer override, receiver off
  task automatic t_mask;
    u_host_cmd_model.wr(`ADDR_OP_CTRL, 8'h40);
    u_host_cmd_model.cmds(2'b10, 2'b00);
    #1;
    check({RX_ON, RX_FRAMING_EN}, 8'h00, "mask");
    check(CMD_TERM_IRQ, 8'h00, "no irq");
    u_host_cmd_model.cmds(2'b01, 2'b00);
    #1;
    check({RX_ON, RX_FRAMING_EN}, 8'h03, "unmask");
    check(CMD_TERM_IRQ, 8'h00, "no irq");
    u_host_cmd_model.cmds(2'b01, 2'b10);
    #1;
    check(RX_ON, 8'h00, "chain um");
    u_host_cmd_model.cmds(2'b10, 2'b01);
    #1;
    check(RX_ON, 8'h01, "chain mu");
    u_host_cmd_model.set_timer(1'b1);
    @(posedge CORE_CLK);
    #1;
    check({RX_ON, RX_FRAMING_EN}, 8'h00, "timer");
    u_host_cmd_model.cmds(2'b01, 2'b00);
    #1;
    check({RX_ON, MASK_TIMER_RST}, 8'h03, "tmr rst");
    u_host_cmd_model.wr(`ADDR_OP_CTRL, 8'h00);
    u_host_cmd_model.cmds(2'b10, 2'b00);
    u_host_cmd_model.wr(`ADDR_OP_CTRL, 8'h40);
    // receive active follows the enable bit one edge after the write
    @(posedge CORE_CLK);
    #1;
    check({RX_ON, RX_FRAMING_EN}, 8'h03, "rx off");
    // a mask strobe while the clock enable is low must leave no trace
    u_host_cmd_model.set_ce(1'b0);
    u_host_cmd_model.cmds(2'b10, 2'b00);
    u_host_cmd_model.set_ce(1'b1);
    @(posedge CORE_CLK);
    #1;
    check({RX_ON, RX_FRAMING_EN}, 8'h03, "frozen");
    $display("t_mask done");
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    SRST = 1'b1;
    repeat (16) @(posedge CORE_CLK);
    SRST <= 1'b0;
    @(posedge CORE_CLK);
    #1;
    check(OP_CTRL | ISO_A_SET | AUX_DEF, 8'h00, "reset regs");
    check(RX_CFG1 | RX_CFG3 | REG_RDATA, 8'h00, "reset rx cfg");
    check({RX_ON, RX_FRAMING_EN, REG_RVALID}, 8'h02, "reset rx");
    check({MASK_TIMER_RST, CMD_TERM_IRQ}, 8'h00, "reset irq");
    t_regs();
    t_preset();
    t_mask();
    stop_test();
  end
endmodule // analog_preset_rx_mask_tb
`default_nettype wire
